// ===== logic/irq_ctl_pkg.sv
// Register map, field positions and reset values of the interrupt control block
`default_nettype none
package irq_ctl_pkg;

  // Register byte addresses on the Wishbone bus (one 32-bit word each)
  localparam logic [7:0] OFS_CORE_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_CONTROL_ONE   = 8'h04;
  localparam logic [7:0] OFS_CONTROL_TWO   = 8'h08;
  localparam logic [7:0] OFS_FLAGS_BANK0   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS_BANK1   = 8'h10;
  localparam logic [7:0] OFS_STATUS_WORD   = 8'h14;

  // core_control fields
  localparam int unsigned BIT_PRIO_TOP     = 3;
  localparam int unsigned BIT_PSV          = 2;

  // interrupt_control_one fields
  localparam int unsigned BIT_NESTING_OFF  = 15;
  localparam int unsigned BIT_DIV_ZERO     = 6;
  localparam int unsigned BIT_ARITH_TRAP   = 4;
  localparam int unsigned BIT_ADDR_TRAP    = 3;
  localparam int unsigned BIT_STACK_TRAP   = 2;
  localparam int unsigned BIT_OSC_TRAP     = 1;

  // interrupt_control_two fields
  localparam int unsigned BIT_ALT_TABLE    = 15;
  localparam int unsigned BIT_TIMED_HOLD   = 14;
  localparam int unsigned BIT_PIN_POL_LO   = 0;

  // cpu_status_word field: low priority bits at 7:5
  localparam int unsigned BIT_PRIO_LOW_LO  = 5;

  // Request flag positions
  localparam int unsigned BIT_EXT_PIN0     = 0;
  localparam int unsigned BIT_EXT_PIN1     = 4;
  localparam int unsigned BIT_EXT_PIN2     = 13;

  // Implemented bits of each register; all others read zero
  localparam logic [15:0] MASK_CORE        = 16'h000C;
  localparam logic [15:0] MASK_CONTROL_ONE = 16'h805E;
  localparam logic [15:0] MASK_CONTROL_TWO = 16'hC007;
  localparam logic [15:0] WMASK_CONTROL_TWO = 16'h8007;
  localparam logic [15:0] MASK_BANK0       = 16'h3FEF;
  localparam logic [15:0] MASK_BANK1       = 16'h20DB;
  localparam logic [15:0] MASK_STATUS_WORD = 16'h00E0;

  // Reset values
  localparam logic [15:0] RST_REG16        = 16'h0000;
  localparam logic [2:0]  RST_PRIO_LOW     = 3'h0;
  localparam logic [2:0]  RST_PIN_POL      = 3'h0;

  // Number of external interrupt pins
  localparam int unsigned EXT_PINS         = 3;

endpackage : irq_ctl_pkg
`default_nettype wire

// ===== logic/pin_event_if.sv
// Polarity selects and detected pin events between control and edge detector
`timescale 1ns/1ps
`default_nettype none
interface pin_event_if;
  logic [2:0] pol;        // 1 = falling edge, 0 = rising edge
  logic [2:0] pin_event;  // One-cycle pulse per detected edge
  modport ctl (output pol, input pin_event);
  modport det (input pol, output pin_event);
endinterface : pin_event_if
`default_nettype wire

// ===== logic/ext_pin_edge.sv
// Synchroniser and polarity-selected edge detector for external pins
`timescale 1ns/1ps
`default_nettype none
module ext_pin_edge (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] pins_i,
  pin_event_if.det        evt
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] level;
    logic       primed;
    logic [1:0] fill;
    logic [2:0] pulse;
  } det_s;

  det_s st_r;
  det_s st_nxt;

  // A change counts only when the second and third stages agree;
  // the first stage feeds nothing but the second
  always_comb begin
    logic [2:0] agree;
    logic [2:0] change;
    agree         = ~(st_r.s2 ^ st_r.s3);
    change        = agree & (st_r.s3 ^ st_r.level);
    st_nxt        = st_r;
    st_nxt.s1     = pins_i;
    st_nxt.s2     = st_r.s1;
    st_nxt.s3     = st_r.s2;
    st_nxt.pulse  = 3'h0;
    if (!st_r.primed) begin
      // Wait until all three stages hold real pin samples, then take
      // the agreed level without an event: a pin high at reset is quiet
      st_nxt.level = st_r.s3;
      if (!(&st_r.fill)) begin
        st_nxt.fill = st_r.fill + 2'h1;
      end else begin
        st_nxt.primed = &agree;
      end
    end else begin
      st_nxt.level = st_r.level ^ change;
      st_nxt.pulse = change & (evt.pol ^ st_r.s3);
    end
  end

  // Registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.pin_event = st_r.pulse;

endmodule : ext_pin_edge
`default_nettype wire

// ===== logic/irq_trap_status_control.sv
// Interrupt trap status, control and request flag registers on Wishbone
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Top priority bit reads one above seven
// - Priority level is top bit over low
// - Nesting disable bit stops interrupt nesting
// - Divide-by-zero status set on math trap
// - Math trap sets arithmetic trap status
// - Address trap sets address trap status
// - Stack trap sets stack trap status
// - Oscillator loss trap sets its status
// - Table select picks alternate vector table
// - Read-only bit shows timed interrupt hold
// - Polarity bits pick falling or rising edge
// - Bank zero high flag positions
// - Bank zero low flag positions
// - Bank one flag positions
// - Flags set by request, zero after reset
// - Unimplemented bits read zero, ignore writes
// - Hardware sets flags, only software clears
// - Top priority bit blocks user interrupts
// - Nesting disabled locks low priority bits against software writes; core loads still change them
module irq_trap_status_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic [15:0] bank0_req_i,
  input  wire logic [15:0] bank1_req_i,
  input  wire logic [2:0]  ext_pins_i,
  input  wire logic        trap_math_i,
  input  wire logic        trap_div0_i,
  input  wire logic        trap_addr_i,
  input  wire logic        trap_stack_i,
  input  wire logic        trap_osc_i,
  input  wire logic        trap_entry_i,
  input  wire logic        ipl_load_i,
  input  wire logic [2:0]  ipl_load_val_i,
  input  wire logic        timed_hold_i,
  output logic      [3:0]  prio_level_o,
  output logic             user_irq_block_o,
  output logic             nesting_off_o,
  output logic             alt_table_select_o,
  output logic             program_space_view_o,
  output logic      [15:0] flags0_o,
  output logic      [15:0] flags1_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        prio_top;
    logic [2:0]  prio_low;
    logic        program_space_view;
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] flags0;
    logic [15:0] flags1;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  pin_event_if pev ();

  // Pin synchroniser and edge detector
  ext_pin_edge u_pin_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i (ext_pins_i),
    .evt    (pev.ctl)
  );

  // Polarity selects live in interrupt control register two
  assign pev.pol = st_r.ctl2[irq_ctl_pkg::BIT_PIN_POL_LO +: 3];

  // Byte-lane merge of a 16-bit register; bits outside mask keep old value
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wdat,
                                             input logic [1:0]  sel,
                                             input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
    return (old & ~lanes) | (wdat & lanes);
  endfunction : lane_merge

  // Widen a 16-bit register image to the bus, high half zero
  function automatic logic [31:0] widen(input logic [15:0] val,
                                        input logic [15:0] mask);
    return {16'h0000, val & mask};
  endfunction : widen

  // Bus decode: a request is served once, ack follows one edge later
  logic        req;
  logic        wr;
  logic [15:0] wd;
  logic [15:0] core_img;
  logic [15:0] ctl2_img;
  logic [15:0] sw_img;
  logic [15:0] b0_set;
  logic [15:0] b1_set;
  logic [15:0] ctl1_set;

  assign req = cyc_i & stb_i & ~st_r.ack;
  assign wr  = req & we_i;
  assign wd  = dat_i[15:0];

  // Read images of the composite registers
  assign core_img = {12'h000, st_r.prio_top, st_r.program_space_view, 2'b00};
  assign ctl2_img = {st_r.ctl2[15], timed_hold_i,
                     st_r.ctl2[13:0]};
  assign sw_img   = {8'h00, st_r.prio_low, 5'h00};

  // Flag set sources: peripheral lines, with pin flags from the detector
  always_comb begin
    b0_set = bank0_req_i & irq_ctl_pkg::MASK_BANK0;
    b0_set[irq_ctl_pkg::BIT_EXT_PIN0] = pev.pin_event[0];
    b1_set = bank1_req_i & irq_ctl_pkg::MASK_BANK1;
    b1_set[irq_ctl_pkg::BIT_EXT_PIN1] = pev.pin_event[1];
    b1_set[irq_ctl_pkg::BIT_EXT_PIN2] = pev.pin_event[2];
  end

  // Trap status set sources
  always_comb begin
    ctl1_set = 16'h0000;
    ctl1_set[irq_ctl_pkg::BIT_ARITH_TRAP] = trap_math_i;
    ctl1_set[irq_ctl_pkg::BIT_DIV_ZERO]   = trap_math_i
                                            & trap_div0_i;
    ctl1_set[irq_ctl_pkg::BIT_ADDR_TRAP]  = trap_addr_i;
    ctl1_set[irq_ctl_pkg::BIT_STACK_TRAP] = trap_stack_i;
    ctl1_set[irq_ctl_pkg::BIT_OSC_TRAP]   = trap_osc_i;
  end

  // Next state: software writes first, hardware sets after so set wins
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = req;
    st_nxt.rdata = 32'h0000_0000;

    if (wr) begin
      unique case (adr_i)
        irq_ctl_pkg::OFS_CORE_CONTROL: begin
          // Top bit is clear-only from software
          if (sel_i[0] && !wd[irq_ctl_pkg::BIT_PRIO_TOP]) begin
            st_nxt.prio_top = 1'b0;
          end
          if (sel_i[0]) begin
            st_nxt.program_space_view = wd[irq_ctl_pkg::BIT_PSV];
          end
        end
        irq_ctl_pkg::OFS_CONTROL_ONE: begin
          st_nxt.ctl1 = lane_merge(st_r.ctl1, wd, sel_i[1:0],
                                   irq_ctl_pkg::MASK_CONTROL_ONE);
        end
        irq_ctl_pkg::OFS_CONTROL_TWO: begin
          // Timed-hold status is not stored; it is read live
          st_nxt.ctl2 = lane_merge(st_r.ctl2, wd, sel_i[1:0],
                                   irq_ctl_pkg::WMASK_CONTROL_TWO);
        end
        irq_ctl_pkg::OFS_FLAGS_BANK0: begin
          st_nxt.flags0 = lane_merge(st_r.flags0, wd, sel_i[1:0],
                                     irq_ctl_pkg::MASK_BANK0);
        end
        irq_ctl_pkg::OFS_FLAGS_BANK1: begin
          st_nxt.flags1 = lane_merge(st_r.flags1, wd, sel_i[1:0],
                                     irq_ctl_pkg::MASK_BANK1);
        end
        irq_ctl_pkg::OFS_STATUS_WORD: begin
          // Low bits are frozen for software while nesting is off
          if (sel_i[0] && !st_r.ctl1[irq_ctl_pkg::BIT_NESTING_OFF]) begin
            st_nxt.prio_low = wd[irq_ctl_pkg::BIT_PRIO_LOW_LO +: 3];
          end
        end
        default: begin
          // Unmapped write: acknowledged and dropped
        end
      endcase
    end

    if (req && !we_i) begin
      unique case (adr_i)
        irq_ctl_pkg::OFS_CORE_CONTROL:
          st_nxt.rdata = widen(core_img, irq_ctl_pkg::MASK_CORE);
        irq_ctl_pkg::OFS_CONTROL_ONE:
          st_nxt.rdata = widen(st_r.ctl1, irq_ctl_pkg::MASK_CONTROL_ONE);
        irq_ctl_pkg::OFS_CONTROL_TWO:
          st_nxt.rdata = widen(ctl2_img, irq_ctl_pkg::MASK_CONTROL_TWO);
        irq_ctl_pkg::OFS_FLAGS_BANK0:
          st_nxt.rdata = widen(st_r.flags0, irq_ctl_pkg::MASK_BANK0);
        irq_ctl_pkg::OFS_FLAGS_BANK1:
          st_nxt.rdata = widen(st_r.flags1, irq_ctl_pkg::MASK_BANK1);
        irq_ctl_pkg::OFS_STATUS_WORD:
          st_nxt.rdata = widen(sw_img, irq_ctl_pkg::MASK_STATUS_WORD);
        default:
          st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // CPU core reloads the low level on interrupt entry and return
    if (ipl_load_i) begin
      st_nxt.prio_low = ipl_load_val_i;
    end

    // Hardware sets; a same-cycle software clear loses
    st_nxt.ctl1   = st_nxt.ctl1 | ctl1_set;
    st_nxt.flags0 = st_nxt.flags0 | b0_set;
    st_nxt.flags1 = st_nxt.flags1 | b1_set;
    if (trap_entry_i) begin
      st_nxt.prio_top = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign ack_o                = st_r.ack;
  assign dat_o                = st_r.rdata;
  assign prio_level_o         = {st_r.prio_top, st_r.prio_low};
  assign user_irq_block_o     = st_r.prio_top;
  assign nesting_off_o        = st_r.ctl1[irq_ctl_pkg::BIT_NESTING_OFF];
  assign alt_table_select_o   = st_r.ctl2[irq_ctl_pkg::BIT_ALT_TABLE];
  assign program_space_view_o = st_r.program_space_view;
  assign flags0_o             = st_r.flags0;
  assign flags1_o             = st_r.flags1;

  // Helper for the assertions: bus write hit on each flag bank
  logic wr_b0;
  logic wr_b1;
  assign wr_b0 = wr && (adr_i == irq_ctl_pkg::OFS_FLAGS_BANK0);
  assign wr_b1 = wr && (adr_i == irq_ctl_pkg::OFS_FLAGS_BANK1);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_bound_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged in one cycle");

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  trap_math_a: assert property (
    trap_math_i |=> st_r.ctl1[irq_ctl_pkg::BIT_ARITH_TRAP])
    else $error("math trap status not set");

  div_zero_a: assert property (
    $rose(st_r.ctl1[irq_ctl_pkg::BIT_DIV_ZERO]) |->
      $past(trap_math_i && trap_div0_i) ||
      $past(wr && adr_i == irq_ctl_pkg::OFS_CONTROL_ONE))
    else $error("divide-by-zero status set without cause");

  prio_top_set_a: assert property (
    trap_entry_i |=> prio_level_o[3] && user_irq_block_o)
    else $error("trap entry did not raise top priority bit");

  prio_top_hw_a: assert property (
    $rose(prio_level_o[3]) |-> $past(trap_entry_i))
    else $error("top priority bit set without trap entry");

  nest_lock_a: assert property (
    nesting_off_o && !ipl_load_i |=> $stable(prio_level_o[2:0]))
    else $error("low priority bits changed while nesting off");

  flag_sticky_a: assert property (
    |($past(flags0_o) & ~flags0_o) |-> $past(wr_b0))
    else $error("bank0 flag cleared without software write");

  flag1_sticky_a: assert property (
    |($past(flags1_o) & ~flags1_o) |-> $past(wr_b1))
    else $error("bank1 flag cleared without software write");

  pin_flag_a: assert property (
    pev.pin_event[2] |=> flags1_o[irq_ctl_pkg::BIT_EXT_PIN2])
    else $error("pin event did not set its flag");

  unused_zero_a: assert property (
    ((flags0_o & ~irq_ctl_pkg::MASK_BANK0) == 16'h0000) &&
    ((flags1_o & ~irq_ctl_pkg::MASK_BANK1) == 16'h0000) &&
    (dat_o[31:16] == 16'h0000))
    else $error("unimplemented bit reads non-zero");

  // Request lines that must land in a flag; pin bits come from the
  // detector instead, so they are left out of these checks
  logic [15:0] req0_hit;
  logic [15:0] req1_hit;
  always_comb begin
    req0_hit = bank0_req_i & irq_ctl_pkg::MASK_BANK0;
    req0_hit[irq_ctl_pkg::BIT_EXT_PIN0] = 1'b0;
    req1_hit = bank1_req_i & irq_ctl_pkg::MASK_BANK1;
    req1_hit[irq_ctl_pkg::BIT_EXT_PIN1] = 1'b0;
    req1_hit[irq_ctl_pkg::BIT_EXT_PIN2] = 1'b0;
  end

  core_read_a: assert property (
    ack_o && $past(!we_i && adr_i == irq_ctl_pkg::OFS_CORE_CONTROL) |->
      dat_o[irq_ctl_pkg::BIT_PRIO_TOP] == $past(prio_level_o[3]))
    else $error("core control read shows wrong top priority bit");

  hold_read_a: assert property (
    ack_o && $past(!we_i && adr_i == irq_ctl_pkg::OFS_CONTROL_TWO) |->
      dat_o[irq_ctl_pkg::BIT_TIMED_HOLD] == $past(timed_hold_i))
    else $error("timed hold status read back wrong");

  nest_write_a: assert property (
    wr && sel_i[1] && adr_i == irq_ctl_pkg::OFS_CONTROL_ONE |=>
      nesting_off_o == $past(wd[irq_ctl_pkg::BIT_NESTING_OFF]))
    else $error("nesting disable bit did not follow the write");

  alt_write_a: assert property (
    wr && sel_i[1] && adr_i == irq_ctl_pkg::OFS_CONTROL_TWO |=>
      alt_table_select_o == $past(wd[irq_ctl_pkg::BIT_ALT_TABLE]))
    else $error("table select bit did not follow the write");

  div_zero_set_a: assert property (
    trap_math_i && trap_div0_i |=> st_r.ctl1[irq_ctl_pkg::BIT_DIV_ZERO])
    else $error("divide-by-zero status not set");

  addr_trap_a: assert property (
    trap_addr_i |=> st_r.ctl1[irq_ctl_pkg::BIT_ADDR_TRAP])
    else $error("address trap status not set");

  stack_trap_a: assert property (
    trap_stack_i |=> st_r.ctl1[irq_ctl_pkg::BIT_STACK_TRAP])
    else $error("stack trap status not set");

  osc_trap_a: assert property (
    trap_osc_i |=> st_r.ctl1[irq_ctl_pkg::BIT_OSC_TRAP])
    else $error("oscillator loss trap status not set");

  flag_upper_a: assert property (
    (|req0_hit[15:8]) |=> &(flags0_o[15:8] | ~$past(req0_hit[15:8])))
    else $error("bank0 upper request did not set its flag");

  flag_lower_a: assert property (
    (|req0_hit[7:0]) |=> &(flags0_o[7:0] | ~$past(req0_hit[7:0])))
    else $error("bank0 lower request did not set its flag");

  flag1_set_a: assert property (
    (|req1_hit) |=> &(flags1_o | ~$past(req1_hit)))
    else $error("bank1 request did not set its flag");

  reset_clear_a: assert property (
    $fell(rst_i) |-> flags0_o == 16'h0000 && flags1_o == 16'h0000)
    else $error("request flags not clear after reset");

endmodule : irq_trap_status_control
`default_nettype wire

// ===== sim/irq_source_model.sv
// Model of the trap sources, peripherals and pins around the block
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  input  wire logic        clk_i,
  output logic      [15:0] req0_o,
  output logic      [15:0] req1_o,
  output logic      [2:0]  pins_o,
  output logic      [4:0]  trap_o,
  output logic             entry_o,
  output logic             load_o,
  output logic      [2:0]  load_val_o,
  output logic             hold_o
);
  // Idle sources; pins rest low so priming sees no edge
  initial begin
    {req0_o, req1_o, trap_o, entry_o, load_o} = '0;
    {pins_o, load_val_o, hold_o} = '0;
  end
  // Peripheral requests are one-cycle strobes
  task automatic req(input logic [15:0] a, input logic [15:0] b);
    req0_o <= a;
    req1_o <= b;
    @(posedge clk_i);
    req0_o <= 16'h0000;
    req1_o <= 16'h0000;
  endtask : req
  // Trap bits: 0 math, 1 divide, 2 address, 3 stack, 4 clock loss
  task automatic trap(input logic [4:0] t, input logic e);
    trap_o  <= t;
    entry_o <= e;
    @(posedge clk_i);
    trap_o  <= 5'h00;
    entry_o <= 1'b0;
  endtask : trap
  // Core loads a new low level; the value is not held afterwards
  task automatic load(input logic [2:0] v);
    load_o     <= 1'b1;
    load_val_o <= v;
    @(posedge clk_i);
    load_o     <= 1'b0;
    load_val_o <= ~v;
  endtask : load
endmodule : irq_source_model
`default_nettype wire

// ===== sim/test_irq_trap_status_control.sv
// Self-checking bench of the trap status and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module test_irq_trap_status_control;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = '0;
  logic        we    = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, ublk, nest, alt, program_space_view, entry, load, hold;
  logic [3:0]  prio;
  logic [15:0] fl0, fl1, r0, r1, v;
  logic [2:0]  pins, lval, pf;
  logic [4:0]  tr;
  logic [15:0] q[$];
  logic [15:0] ones[5] = '{16'h0004, 16'h805E, 16'h8007, 16'h3FEF,
                           16'h20DB};
  int n_errors = 0;
  int checked = 0;
  int cyc_cnt = 0;
  int seed = 32'he6a6;

  assign pf = {fl1[13], fl1[4], fl0[0]};

  irq_source_model src (.clk_i(clk_i), .req0_o(r0), .req1_o(r1),
    .pins_o(pins), .trap_o(tr), .entry_o(entry), .load_o(load),
    .load_val_o(lval), .hold_o(hold));

  irq_trap_status_control DUT (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(wdat), .dat_o(dat_o), .we_i(we), .sel_i(4'h3),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .bank0_req_i(r0),
    .bank1_req_i(r1), .ext_pins_i(pins), .trap_math_i(tr[0]),
    .trap_div0_i(tr[1]), .trap_addr_i(tr[2]), .trap_stack_i(tr[3]),
    .trap_osc_i(tr[4]), .trap_entry_i(entry), .ipl_load_i(load),
    .ipl_load_val_i(lval), .timed_hold_i(hold), .prio_level_o(prio),
    .user_irq_block_o(ublk), .nesting_off_o(nest),
    .alt_table_select_o(alt), .program_space_view_o(program_space_view),
    .flags0_o(fl0), .flags1_o(fl1));

  // Clock of 100 ns period
  always #50 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Classic cycle; waits on ack, the timeout bounds a hang
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Expected read value is noted before the cycle starts
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // Each read answer is matched against the oldest note
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we === 1'b0)
      chk("read", dat_o, {16'h0000, q.pop_front()});

  // Hang guard, far above the six hundred or so cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("level", {28'h0, prio}, 32'h0);
    chk("flags", {fl1, fl0}, 32'h0);
    for (int a = 0; a < 7; a++) rd(8'(a * 4), 16'h0000);
    $display("reset test done");
    // Software may set only implemented bits; top level bit refuses
    for (int i = 0; i < 5; i++) begin
      wr(8'(i * 4), 16'hFFFF);
      rd(8'(i * 4), ones[i]);
    end
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 16'h0000);
    chk("ctl", {29'h0, nest, alt, program_space_view}, 32'h7);
    for (int i = 0; i < 5; i++) begin
      wr(8'(i * 4), 16'h0000);
      rd(8'(i * 4), 16'h0000);
    end
    chk("ctl", {29'h0, nest, alt, program_space_view}, 32'h0);
    $display("register test done");
    // First all traps, then divide without math, then random mixes
    for (int i = 0; i < 8; i++) begin
      v = (i < 2) ? (i ? 16'h0002 : 16'h001F) : 16'($random(seed));
      src.trap(v[4:0], 1'b0);
      rd(8'h04, {9'h0, v[0] & v[1], 1'b0, v[0], v[2], v[3], v[4],
                 1'b0});
      wr(8'h04, 16'h0000);
    end
    src.hold_o <= 1'b1;
    rd(8'h08, 16'h4000);
    src.hold_o <= 1'b0;
    wr(8'h08, 16'h4000);
    rd(8'h08, 16'h0000);
    $display("trap test done");
    src.load(3'h5);
    @(negedge clk_i);
    chk("level", {27'h0, ublk, prio}, 32'h05);
    @(posedge clk_i);
    rd(8'h14, 16'h00A0);
    rd(8'h00, 16'h0000);
    src.trap(5'h00, 1'b1);
    @(negedge clk_i);
    chk("level", {27'h0, ublk, prio}, 32'h1D);
    @(posedge clk_i);
    rd(8'h00, 16'h0008);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h000C);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h0000);
    chk("level", {27'h0, ublk, prio}, 32'h05);
    // Nesting off locks the low level bits against software
    wr(8'h04, 16'h8000);
    wr(8'h14, 16'h0000);
    rd(8'h14, 16'h00A0);
    chk("nest", {31'h0, nest}, 32'h1);
    wr(8'h04, 16'h0000);
    wr(8'h14, 16'h0060);
    rd(8'h14, 16'h0060);
    $display("priority test done");
    // Walk every source bit; pin positions must stay clear here
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 16; i++) begin
        v = 16'h0001 << i;
        src.req(b ? 16'h0000 : v, b ? v : 16'h0000);
        repeat (2) @(posedge clk_i);
        chk("flags", {fl1, fl0}, b ? {v & 16'h00CB, 16'h0000}
            : {16'h0000, v & 16'h3FEE});
        wr(b ? 8'h10 : 8'h0C, 16'h0000);
      end
    v = 16'($random(seed));
    src.req(v, ~v);
    @(posedge clk_i);
    chk("flags", {fl1, fl0}, {~v & 16'h00CB, v & 16'h3FEE});
    wr(8'h0C, 16'h0000);
    wr(8'h10, 16'h0000);
    rd(8'h0C, 16'h0000);
    $display("flag test done");
    // Each pin: rising then falling edge under both polarities
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 2; s++) begin
        wr(8'h08, 16'(s << p));
        for (int k = 0; k < 2; k++) begin
          src.pins_o[p] <= ~src.pins_o[p];
          repeat (8) @(posedge clk_i);
          chk("pin", {31'h0, pf[p]}, {31'h0, 1'(k == s)});
          wr(8'h0C, 16'h0000);
          wr(8'h10, 16'h0000);
        end
      end
    $display("pin test done");
    stop_test();
  end
endmodule : test_irq_trap_status_control
`default_nettype wire
